// ### src/adc_cfg_pkg.sv
package adc_cfg_pkg;

  // ==========================================================================
  // Serial word layout
  localparam int          WORD_BITS     = 16;
  localparam int          ADDR_BITS     = 5;
  localparam int          DATA_BITS     = 11;
  localparam int          NUM_REGS      = 32;
  localparam logic [3:0]  LAST_BIT_IDX  = 4'hF;

  // ==========================================================================
  // Configuration register indices and fields
  localparam logic [4:0]  REG_GENERAL   = 5'h00;
  localparam logic [4:0]  REG_PATTERN   = 5'h0A;
  localparam logic [4:0]  REG_OUTPUT    = 5'h0D;
  localparam logic [10:0] REG_DEFAULT   = 11'h000;

  localparam int          GEN_SOFT_RST  = 10;
  localparam int          GEN_REF_INT   = 5;
  localparam int          GEN_PDN       = 0;
  localparam int          PAT_LSB       = 5;
  localparam int          PAT_MSB       = 7;
  localparam int          PAT_OFFSET    = 9;
  localparam logic [2:0]  PAT_DESKEW    = 3'h1;
  localparam logic [2:0]  PAT_SYNC      = 3'h2;
  localparam int          OUT_OVRD      = 10;
  localparam int          OUT_LSB_FIRST = 6;
  localparam int          OUT_GAIN      = 5;
  localparam int          OUT_RISING    = 4;
  localparam int          OUT_14X       = 2;
  localparam int          OUT_DDR       = 1;
  localparam int          OUT_TWO_WIRE  = 0;

  // ==========================================================================
  // Four-level strap codes
  localparam logic [1:0]  LVL_GND       = 2'h0;
  localparam logic [1:0]  LVL_3_8       = 2'h1;
  localparam logic [1:0]  LVL_5_8       = 2'h2;
  localparam logic [1:0]  LVL_FULL      = 2'h3;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          COMMIT_NS     = 100;
  localparam int          COMMIT_CYC    = (COMMIT_NS / CLK_PERIOD_NS < 1) ? 1
                                          : COMMIT_NS / CLK_PERIOD_NS;
  localparam int          RST_PULSE_NS  = 10;
  localparam int          RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;

  // ==========================================================================
  // Bus map
  localparam logic [11:0] ADDR_CTRL     = 12'h080;
  localparam logic [11:0] ADDR_STATUS   = 12'h084;
  localparam int          CTRL_PORT_EN  = 0;
  localparam int          CTRL_SERIAL   = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h3;

  typedef enum logic {COMMIT_IDLE, COMMIT_WAIT} commit_state_type;

endpackage : adc_cfg_pkg

// ### src/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : pin_sync

// ### src/adc_config_control.sv
`timescale 1ns/10ps
module adc_config_control (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_enable_n,
  input  wire logic        serial_clock,
  input  wire logic        serial_in_line,
  input  wire logic        reset_pin,
  input  wire logic        power_down_pin,
  input  wire logic [1:0]  sen_strap_code,
  input  wire logic [1:0]  strap_interface_mode,
  input  wire logic [1:0]  strap_serialize_edge,
  input  wire logic [1:0]  strap_reserved,
  input  wire logic [1:0]  strap_order_format,
  output logic             pdn_global,
  output logic             ref_internal,
  output logic             coarse_gain_on,
  output logic             pattern_sync,
  output logic             pattern_deskew,
  output logic             ddr_bit_clock,
  output logic             two_wire,
  output logic             serialize_14x,
  output logic             capture_rising,
  output logic             lsb_first,
  output logic             offset_binary
);

  localparam int DW = adc_cfg_pkg::DATA_BITS;
  localparam int CW = $clog2(adc_cfg_pkg::COMMIT_CYC + 1);
  localparam int RW = $clog2(adc_cfg_pkg::RST_PULSE_CYC + 1);
  localparam logic [CW-1:0] COMMIT_LOAD = CW'(adc_cfg_pkg::COMMIT_CYC - 1);
  localparam logic [RW-1:0] RST_LIMIT   = RW'(adc_cfg_pkg::RST_PULSE_CYC);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [adc_cfg_pkg::NUM_REGS-1:0][DW-1:0] bank;
    logic                                     sclk_prev;
    logic [3:0]                               bit_cnt;
    logic [14:0]                              shift;
    adc_cfg_pkg::commit_state_type            cstate;
    logic [CW-1:0]                            delay_cnt;
    logic [15:0]                              word;
    logic [RW-1:0]                            rst_cnt;
    logic [15:0]                              commits;
    logic [1:0]                               ctrl;
    logic                                     wr_pend;
    logic [11:0]                              dp_addr;
    logic [31:0]                              rdata;
    logic                                     ready;
    logic [10:0]                              eff;
  } state_type;

  state_type   state_reg;
  state_type   state_next;
  logic [14:0] pins_s;
  logic        sen_n_s;
  logic        sclk_s;
  logic        serial_in_line_s;
  logic        rst_s;
  logic        pdn_s;
  logic [1:0]  sen_code_s;
  logic [1:0]  mode_s;
  logic [1:0]  edge_s;
  logic [1:0]  resv_s;
  logic [1:0]  fmt_s;

  // ==========================================================================
  // Pin synchronisers
  // Every pin, the shift clock included, is sampled by hclk. With a 10 ns
  // clock the shift clock must keep each level for at least two hclk
  // periods; 20 MHz with a balanced duty cycle meets that.
  pin_sync #(
    .WIDTH (15)
  ) pin_sync_inst (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({serial_enable_n, serial_clock, serial_in_line, reset_pin,
             power_down_pin, sen_strap_code, strap_interface_mode,
             strap_serialize_edge, strap_reserved, strap_order_format}),
    .q     (pins_s)
  );

  assign sen_n_s    = pins_s[14];
  assign sclk_s     = pins_s[13];
  assign serial_in_line_s    = pins_s[12];
  assign rst_s      = pins_s[11];
  assign pdn_s      = pins_s[10];
  assign sen_code_s = pins_s[9:8];
  assign mode_s     = pins_s[7:6];
  assign edge_s     = pins_s[5:4];
  assign resv_s     = pins_s[3:2];
  assign fmt_s      = pins_s[1:0];

  // ==========================================================================
  // Strap decoders, each returns two function bits
  // Enable strap: {internal reference, coarse gain}.
  function automatic logic [1:0] decode_sen(input logic [1:0] code);
    unique case (code)
      adc_cfg_pkg::LVL_GND:  decode_sen = 2'h0;
      adc_cfg_pkg::LVL_3_8:  decode_sen = 2'h1;
      adc_cfg_pkg::LVL_5_8:  decode_sen = 2'h3;
      adc_cfg_pkg::LVL_FULL: decode_sen = 2'h2;
    endcase
  endfunction : decode_sen

  // First strap: {ddr bit clock, two wire}. The unused level acts as ground.
  function automatic logic [1:0] decode_mode(input logic [1:0] code);
    unique case (code)
      adc_cfg_pkg::LVL_GND:  decode_mode = 2'h2;
      adc_cfg_pkg::LVL_3_8:  decode_mode = 2'h2;
      adc_cfg_pkg::LVL_5_8:  decode_mode = 2'h1;
      adc_cfg_pkg::LVL_FULL: decode_mode = 2'h3;
    endcase
  endfunction : decode_mode

  // Second strap: {14x serialization, rising capture edge}.
  function automatic logic [1:0] decode_edge(input logic [1:0] code);
    unique case (code)
      adc_cfg_pkg::LVL_GND:  decode_edge = 2'h0;
      adc_cfg_pkg::LVL_3_8:  decode_edge = 2'h2;
      adc_cfg_pkg::LVL_5_8:  decode_edge = 2'h3;
      adc_cfg_pkg::LVL_FULL: decode_edge = 2'h1;
    endcase
  endfunction : decode_edge

  // Fourth strap: {lsb first, offset binary}.
  function automatic logic [1:0] decode_format(input logic [1:0] code);
    unique case (code)
      adc_cfg_pkg::LVL_GND:  decode_format = 2'h0;
      adc_cfg_pkg::LVL_3_8:  decode_format = 2'h1;
      adc_cfg_pkg::LVL_5_8:  decode_format = 2'h3;
      adc_cfg_pkg::LVL_FULL: decode_format = 2'h2;
    endcase
  endfunction : decode_format

  // ==========================================================================
  // Bus read multiplexer
  function automatic logic [31:0] read_word(
    input logic [11:0]                              addr,
    input logic [adc_cfg_pkg::NUM_REGS-1:0][DW-1:0] bank,
    input logic [1:0]                               ctrl,
    input logic [31:0]                              status
  );
    read_word = 32'h0000_0000;
    if (addr < adc_cfg_pkg::ADDR_CTRL) begin
      read_word = {21'h0, bank[addr[6:2]]};
    end else if (addr[11:2] == adc_cfg_pkg::ADDR_CTRL[11:2]) begin
      read_word = {30'h0, ctrl};
    end else if (addr[11:2] == adc_cfg_pkg::ADDR_STATUS[11:2]) begin
      read_word = status;
    end
  endfunction : read_word

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic              sclk_fall;
    logic              serial_on;
    logic [4:0]        waddr;
    logic [DW-1:0]     wdata;
    logic [DW-1:0]     r_gen;
    logic [DW-1:0]     r_pat;
    logic [DW-1:0]     r_out;
    logic              ovrd;
    logic [1:0]        sen_dec;
    logic [1:0]        mode_dec;
    logic [1:0]        edge_dec;
    logic [1:0]        fmt_dec;
    logic [2:0]        pat;
    logic [10:0]       eff;
    logic [31:0]       status;

    state_next           = state_reg;
    eff                  = 11'h000;
    sclk_fall            = state_reg.sclk_prev & ~sclk_s;
    serial_on            = state_reg.ctrl[adc_cfg_pkg::CTRL_SERIAL];
    waddr                = state_reg.word[15:11];
    wdata                = state_reg.word[10:0];
    state_next.sclk_prev = sclk_s;

    // Bus data phase: the write lands one cycle after its address phase.
    if (state_reg.wr_pend && state_reg.dp_addr[11:2] == adc_cfg_pkg::ADDR_CTRL[11:2]) begin
      state_next.ctrl = hwdata[1:0];
    end
    state_next.wr_pend = 1'b0;
    state_next.ready   = 1'b1;

    // Shift register: only falling edges inside an enabled window count.
    if (sen_n_s || !serial_on || !state_reg.ctrl[adc_cfg_pkg::CTRL_PORT_EN]) begin
      state_next.bit_cnt = 4'h0;
    end else if (sclk_fall) begin
      state_next.shift = {state_reg.shift[13:0], serial_in_line_s};
      if (state_reg.bit_cnt == adc_cfg_pkg::LAST_BIT_IDX) begin
        state_next.bit_cnt   = 4'h0;
        state_next.word      = {state_reg.shift, serial_in_line_s};
        state_next.cstate    = adc_cfg_pkg::COMMIT_WAIT;
        state_next.delay_cnt = COMMIT_LOAD;
      end else begin
        state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
      end
    end

    // Commit delay: the word reaches the bank a fixed time after the edge.
    unique case (state_reg.cstate)
      adc_cfg_pkg::COMMIT_IDLE: begin
      end
      adc_cfg_pkg::COMMIT_WAIT: begin
        if (state_reg.delay_cnt == '0) begin
          state_next.cstate  = adc_cfg_pkg::COMMIT_IDLE;
          state_next.commits = state_reg.commits + 16'h0001;
          if (waddr == adc_cfg_pkg::REG_GENERAL && wdata[adc_cfg_pkg::GEN_SOFT_RST]) begin
            for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
              state_next.bank[i] = adc_cfg_pkg::REG_DEFAULT;
            end
          end else begin
            state_next.bank[waddr] = wdata;
          end
        end else begin
          state_next.delay_cnt = state_reg.delay_cnt - CW'(1);
        end
      end
    endcase

    // Reset pin: a qualified high level clears the bank and any partial word.
    if (rst_s) begin
      if (state_reg.rst_cnt != RST_LIMIT) begin
        state_next.rst_cnt = state_reg.rst_cnt + RW'(1);
      end
    end else begin
      state_next.rst_cnt = '0;
    end
    if (rst_s && state_next.rst_cnt == RST_LIMIT) begin
      for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
        state_next.bank[i] = adc_cfg_pkg::REG_DEFAULT;
      end
      state_next.cstate  = adc_cfg_pkg::COMMIT_IDLE;
      state_next.bit_cnt = 4'h0;
    end

    // Effective configuration from the registered bank and the straps.
    r_gen    = state_reg.bank[adc_cfg_pkg::REG_GENERAL];
    r_pat    = state_reg.bank[adc_cfg_pkg::REG_PATTERN];
    r_out    = state_reg.bank[adc_cfg_pkg::REG_OUTPUT];
    ovrd     = r_out[adc_cfg_pkg::OUT_OVRD];
    sen_dec  = decode_sen(sen_code_s);
    mode_dec = decode_mode(mode_s);
    edge_dec = decode_edge(edge_s);
    fmt_dec  = decode_format(fmt_s);
    pat      = r_pat[adc_cfg_pkg::PAT_MSB:adc_cfg_pkg::PAT_LSB];

    // Bits 0..2: power down, sync, deskew.
    if (serial_on) begin
      eff[0] = pdn_s | r_gen[adc_cfg_pkg::GEN_PDN];
      eff[1] = (pat == adc_cfg_pkg::PAT_SYNC);
      eff[2] = (pat == adc_cfg_pkg::PAT_DESKEW);
    end else begin
      eff[0] = pdn_s | (sclk_s & ~serial_in_line_s);
      eff[1] = ~sclk_s & serial_in_line_s;
      eff[2] = sclk_s & serial_in_line_s;
    end

    // Bits 3..4: internal reference, coarse gain.
    if (serial_on) begin
      eff[3] = r_gen[adc_cfg_pkg::GEN_REF_INT];
      eff[4] = ovrd & r_out[adc_cfg_pkg::OUT_GAIN];
    end else begin
      eff[3] = sen_dec[1];
      eff[4] = sen_dec[0];
    end

    // Bits 5..10: strap-governed output functions.
    if (ovrd) begin
      eff[5]  = r_out[adc_cfg_pkg::OUT_DDR];
      eff[6]  = r_out[adc_cfg_pkg::OUT_TWO_WIRE];
      eff[7]  = r_out[adc_cfg_pkg::OUT_14X];
      eff[8]  = r_out[adc_cfg_pkg::OUT_RISING];
      eff[9]  = r_out[adc_cfg_pkg::OUT_LSB_FIRST];
      eff[10] = r_pat[adc_cfg_pkg::PAT_OFFSET];
    end else begin
      eff[5]  = mode_dec[1];
      eff[6]  = mode_dec[0];
      eff[7]  = edge_dec[1];
      eff[8]  = edge_dec[0];
      eff[9]  = fmt_dec[1];
      eff[10] = fmt_dec[0];
    end
    state_next.eff = eff;

    // Bus address phase; the read sees a control write landing this cycle.
    status = {state_reg.commits, 3'h0, resv_s, state_reg.eff};
    if (hsel && htrans[1] && hready) begin
      state_next.wr_pend = hwrite;
      state_next.dp_addr = haddr[11:0];
      if (!hwrite) begin
        state_next.rdata = read_word(haddr[11:0], state_reg.bank, state_next.ctrl, status);
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg       <= '0;
      state_reg.ctrl  <= adc_cfg_pkg::CTRL_RESET;
      state_reg.ready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  // Straps feed bits 5..10 continuously while the override bit is clear, and bits 3..4
  // while serial mode is off, so no reset is needed to pick them up; they appear three
  // hclk edges after hresetn releases.
  assign hrdata         = state_reg.rdata;
  assign hreadyout      = state_reg.ready;
  assign hresp          = 1'b0;
  assign pdn_global     = state_reg.eff[0];
  assign pattern_sync   = state_reg.eff[1];
  assign pattern_deskew = state_reg.eff[2];
  assign ref_internal   = state_reg.eff[3];
  assign coarse_gain_on = state_reg.eff[4];
  assign ddr_bit_clock  = state_reg.eff[5];
  assign two_wire       = state_reg.eff[6];
  assign serialize_14x  = state_reg.eff[7];
  assign capture_rising = state_reg.eff[8];
  assign lsb_first      = state_reg.eff[9];
  assign offset_binary  = state_reg.eff[10];

endmodule : adc_config_control

// ### testbench/adc_config_control_monitor.sv
`timescale 1ns/10ps
module adc_config_control_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        serial_clock,
  input wire logic        serial_in_line,
  input wire logic        power_down_pin,
  input wire logic [1:0]  sen_strap_code,
  input wire logic        pdn_global,
  input wire logic        ref_internal,
  input wire logic        coarse_gain_on,
  input wire logic        pattern_sync,
  input wire logic        pattern_deskew
);
  logic       ctrl_pend;
  logic       strap_use;
  logic [2:0] quiet;
  logic       settled;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================================
  // Mode tracking
  // Strap decode is judged only a while after the last mode write, because
  // the output flops lag a mode change by a few cycles.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_pend <= 1'b0;
      strap_use <= 1'b0;
      quiet     <= 3'h0;
    end else begin
      ctrl_pend <= hsel && htrans[1] && hready && hwrite && haddr[11:0] == 12'h080;
      if (ctrl_pend) begin
        strap_use <= !hwdata[1];
      end
      quiet <= ctrl_pend ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  end
  assign settled = strap_use && quiet == 3'h7;

  // ==========================================================================
  // Properties
  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_unmapped_zero: assert property (hsel && htrans[1] && hready && !hwrite
    && haddr[11:0] > 12'h084 |=> hrdata == 32'h0) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite)
    |=> $stable(hrdata)) else $error("hrdata changed without read");
  chk_pin_pdn: assert property (power_down_pin [*5] |-> pdn_global)
    else $error("power down pin ignored");
  chk_pattern_excl: assert property (!(pattern_sync && pattern_deskew))
    else $error("both patterns on");
  chk_strap_pattern: assert property ((settled
    && $stable({serial_clock, serial_in_line})) [*5]
    |-> pattern_sync == (!serial_clock && serial_in_line)
    && pattern_deskew == (serial_clock && serial_in_line)) else $error("strap pattern wrong");
  chk_strap_pdn: assert property ((settled && $stable({serial_clock, serial_in_line,
    power_down_pin})) [*5] |-> pdn_global == (serial_clock && !serial_in_line || power_down_pin))
    else $error("strap power down wrong");
  chk_strap_level: assert property ((settled && $stable(sen_strap_code)) [*5]
    |-> ref_internal == sen_strap_code[1] && coarse_gain_on == ^sen_strap_code)
    else $error("enable strap decode wrong");
endmodule : adc_config_control_monitor

bind adc_config_control adc_config_control_monitor adc_config_control_monitor_inst (.*);

// ### testbench/host_serial.sv
`timescale 1ns/10ps
module host_serial (
  input  wire logic hclk,
  output logic      serial_enable_n,
  output logic      serial_clock,
  output logic      serial_in_line
);
  initial begin
    serial_enable_n = 1'b1;
    serial_clock    = 1'b1;
    serial_in_line  = 1'b0;
  end

  // ==========================================================================
  // Frames
  // The clock idles high so each bit is taken on a falling edge; after a frame the
  // data line flips so that a stale bit cannot pass for a good one.
  task automatic send(input logic [63:0] bits, input int n, input logic hold_off,
                      input realtime t_low);
    @(posedge hclk);
    #2;
    serial_enable_n = hold_off;
    for (int i = 63; i > 63 - n; i--) begin
      serial_in_line = bits[i];
      #62.5;
      serial_clock = 1'b0;
      #(t_low);
      serial_clock = 1'b1;
    end
    #62.5;
    serial_enable_n = 1'b1;
    serial_in_line  = ~serial_in_line;
  endtask : send

  task automatic set_levels(input logic clk_level, input logic data_level);
    @(posedge hclk);
    #2;
    serial_clock   = clk_level;
    serial_in_line = data_level;
  endtask : set_levels
endmodule : host_serial

// ### testbench/adc_config_control_tb.sv
`timescale 1ns/10ps
module adc_config_control_tb;
  localparam logic [7:0] IF_TAB   = 8'hDA;
  localparam logic [7:0] EDGE_TAB = 8'h78;
  localparam logic [7:0] FMT_TAB  = 8'hB4;
  localparam int         SETTLE   = adc_cfg_pkg::COMMIT_CYC + 8;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, reset_pin, power_down_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0]  hsize;
  logic [1:0]  htrans, sen_strap_code, strap_interface_mode, strap_serialize_edge;
  logic [1:0]  strap_reserved, strap_order_format;
  logic        serial_enable_n, serial_clock, serial_in_line;
  logic        pdn_global, pattern_sync, pattern_deskew, ref_internal, coarse_gain_on;
  logic        ddr_bit_clock, two_wire, serialize_14x, capture_rising, lsb_first, offset_binary;
  logic [10:0] outs;
  int          miscompares;
  int          n_compared;
  wire         hready = hreadyout;
  assign outs = {pdn_global, pattern_sync, pattern_deskew, ref_internal, coarse_gain_on,
                 ddr_bit_clock, two_wire, serialize_14x, capture_rising, lsb_first, offset_binary};
  adc_config_control adc_config_control_inst (.*);
  host_serial host_serial_inst (.*);
  always #5 hclk = ~hclk;

  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      complete_run();
    end
  endtask : wait_ready
  task automatic bus(input logic [11:0] addr, input logic wr, input logic [31:0] data);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, addr};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= data;
    wait_ready();
    rd = hrdata;
    hsel <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [11:0] addr, input logic [31:0] exp);
    bus(addr, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rchk
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle

  // ==========================================================================
  // Scenarios
  task automatic test_bus_reset();
    chk({30'h0, hreadyout, hresp}, 32'h2);
    rchk(12'h080, 32'h3);
    rchk(12'h0FC, 32'h0);
  endtask : test_bus_reset
  task automatic test_straps();
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      strap_interface_mode <= 2'(i);
      strap_serialize_edge <= 2'(i);
      strap_order_format   <= 2'(i);
      settle(6);
      chk({26'h0, outs[5:0]}, {26'h0, IF_TAB[i*2 +: 2], EDGE_TAB[i*2 +: 2],
          FMT_TAB[i*2 +: 2]});
    end
  endtask : test_straps
  task automatic test_strap_pins();
    logic [4:0] e;
    bus(12'h080, 1'b1, 32'h1);
    for (int j = 0; j < 4; j++) begin
      @(posedge hclk);
      sen_strap_code <= 2'(j);
      host_serial_inst.set_levels(j[1], j[0]);
      settle(8);
      e = {j == 2, j == 1, j == 3, j[1], j[1] ^ j[0]};
      chk({27'h0, outs[10:6]}, {27'h0, e});
    end
    bus(12'h080, 1'b1, 32'h3);
    host_serial_inst.set_levels(1'b1, 1'b0);
  endtask : test_strap_pins
  task automatic test_serial();
    logic [15:0] cnt;
    bus(12'h084, 1'b0, 32'h0);
    cnt = rd[31:16];
    host_serial_inst.send({5'h0D, 11'h465, 5'h00, 11'h021, 5'h0A, 11'h240, 7'h7F, 9'h000},
                          55, 1'b0, 400.0);
    settle(SETTLE);
    chk({21'h0, outs}, {21'h0, 11'h6DB});
    rchk(12'h028, 32'h240);
    rchk(12'h000, 32'h021);
    bus(12'h084, 1'b0, 32'h0);
    chk({16'h0, rd[31:16]}, {16'h0, cnt + 16'h3});
  endtask : test_serial
  task automatic test_pdn_pin();
    host_serial_inst.send({5'h00, 11'h020, 48'h0}, 16, 1'b0, 62.5);
    settle(SETTLE);
    chk({30'h0, outs[10], outs[7]}, 32'h1);
    @(posedge hclk);
    power_down_pin <= 1'b1;
    settle(6);
    chk({31'h0, outs[10]}, 32'h1);
    @(posedge hclk);
    power_down_pin <= 1'b0;
  endtask : test_pdn_pin
  task automatic test_no_enable();
    host_serial_inst.send({5'h0A, 11'h000, 48'h0}, 16, 1'b1, 62.5);
    settle(SETTLE);
    rchk(12'h028, 32'h240);
    bus(12'h080, 1'b1, 32'h2);
    host_serial_inst.send({5'h0A, 11'h020, 48'h0}, 16, 1'b0, 62.5);
    settle(SETTLE);
    rchk(12'h028, 32'h240);
    bus(12'h080, 1'b1, 32'h3);
    host_serial_inst.send({5'h0A, 11'h020, 48'h0}, 16, 1'b0, 62.5);
    settle(SETTLE);
    chk({30'h0, outs[9:8]}, 32'h1);
  endtask : test_no_enable
  task automatic test_soft_reset();
    host_serial_inst.send({5'h00, 11'h400, 48'h0}, 16, 1'b0, 62.5);
    settle(SETTLE);
    rchk(12'h000, 32'h0);
    rchk(12'h028, 32'h0);
    host_serial_inst.send({5'h0D, 11'h03F, 48'h0}, 16, 1'b0, 62.5);
    settle(SETTLE);
    chk({31'h0, outs[6]}, 32'h0);
    chk({26'h0, outs[5:0]}, 32'h36);
  endtask : test_soft_reset
  task automatic test_reset_pin();
    host_serial_inst.send({5'h0A, 11'h240, 48'h0}, 16, 1'b0, 62.5);
    settle(SETTLE);
    rchk(12'h028, 32'h240);
    @(posedge hclk);
    reset_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    reset_pin <= 1'b0;
    settle(4);
    bus(12'h028, 1'b1, 32'h7FF);
    rchk(12'h028, 32'h0);
  endtask : test_reset_pin

  // ==========================================================================
  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, reset_pin, power_down_pin} = 4'h0;
    {haddr, hwdata} = 64'h0;
    hsize = 3'h2;
    htrans = 2'h0;
    {sen_strap_code, strap_interface_mode, strap_serialize_edge} = 6'h0;
    strap_reserved = 2'h0;
    strap_order_format = 2'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    test_bus_reset();
    test_straps();
    test_strap_pins();
    test_serial();
    test_pdn_pin();
    test_no_enable();
    test_soft_reset();
    test_reset_pin();
    complete_run();
  end
endmodule : adc_config_control_tb
